// [inc/blank_sig_pkg.sv]
package blank_sig_pkg;

  // frame delimiters and dummy byte sent while receiving
  localparam logic [7:0] FRAME_SOH = 8'h01;
  localparam logic [7:0] FRAME_STX = 8'h02;
  localparam logic [7:0] FRAME_ETX = 8'h03;
  localparam logic [7:0] DUMMY_BYTE = 8'h00;

  // command codes (plain defaults)
  localparam logic [7:0] BLANK_CHECK_CMD = 8'h32;
  localparam logic [7:0] SIGNATURE_CMD = 8'hC0;

  // command frame length field: command byte plus parameters
  localparam logic [7:0] BLANK_CMD_LEN = 8'h07;
  localparam logic [7:0] SIG_CMD_LEN = 8'h01;

  // status codes returned by the target
  localparam logic [7:0] ST_ACK = 8'h06;
  localparam logic [7:0] ST_PARAM_ERR = 8'h05;
  localparam logic [7:0] ST_CSUM_ERR = 8'h07;
  localparam logic [7:0] ST_NACK = 8'h15;
  localparam logic [7:0] ST_BLANK_VERIFY_FAIL = 8'h18;

  // frame byte positions
  localparam int IDX_LEN = 1;
  localparam int IDX_CMD = 2;
  localparam int IDX_FIRST_PRM = 3;
  localparam int IDX_TRAILER = 3;

  // address layout and block size
  localparam int ADDR_W = 24;
  localparam int BLOCK_SHIFT = 11;

  // clock and times
  localparam int CLOCK_MHZ = 10;
  localparam int COMMAND_BUSY_TIMEOUT_US = 1000;
  localparam int BLANK_CHECK_BASE_US = 1000;
  localparam int BLANK_CHECK_PER_BLOCK_US = 500;
  localparam int SIGNATURE_STATUS_TIMEOUT_US = 1000;
  localparam int SIGNATURE_DATA_TIMEOUT_US = 1000;
  localparam int COMMAND_BUSY_TIMEOUT_CYC = COMMAND_BUSY_TIMEOUT_US * CLOCK_MHZ;
  localparam int BLANK_BASE_CYC = BLANK_CHECK_BASE_US * CLOCK_MHZ;
  localparam int BLANK_PER_BLOCK_CYC = BLANK_CHECK_PER_BLOCK_US * CLOCK_MHZ;
  localparam int SIG_STATUS_CYC = SIGNATURE_STATUS_TIMEOUT_US * CLOCK_MHZ;
  localparam int SIG_DATA_CYC = SIGNATURE_DATA_TIMEOUT_US * CLOCK_MHZ;
  localparam int SCK_HALF_CYC = 8;

  // buffer default depth
  localparam int SIG_BUF_DEPTH = 2;

  typedef enum logic [1:0] {
    RES_OK,
    RES_ABNORMAL,
    RES_TIMEOUT,
    RES_DATA_ERR
  } result_t;

endpackage : blank_sig_pkg

// [rtl/blank_sig_host.sv]
`timescale 1ns/10ps
module blank_sig_host #(
  parameter int CMD_TIMEOUT = blank_sig_pkg::COMMAND_BUSY_TIMEOUT_CYC,
  parameter int BLANK_BASE = blank_sig_pkg::BLANK_BASE_CYC,
  parameter int BLANK_PER_BLOCK = blank_sig_pkg::BLANK_PER_BLOCK_CYC,
  parameter int SIG_STATUS_TIMEOUT = blank_sig_pkg::SIG_STATUS_CYC,
  parameter int SIG_DATA_TIMEOUT = blank_sig_pkg::SIG_DATA_CYC,
  parameter int SCK_HALF = blank_sig_pkg::SCK_HALF_CYC,
  parameter int BUF_DEPTH = blank_sig_pkg::SIG_BUF_DEPTH
) (
  input wire logic clock, // system clock
  input wire logic reset, // async, active high
  input wire logic cmd_valid, // request a command
  output logic cmd_ready, // idle, request taken
  input wire logic cmd_signature, // 1 signature, 0 blank check
  input wire logic [23:0] start_addr, // blank check start address
  input wire logic [23:0] end_addr, // blank check end address
  output logic done, // one-cycle completion pulse
  output blank_sig_pkg::result_t result, // completion class
  output logic [7:0] status_code, // first status byte received
  output logic sig_valid, // signature byte available
  input wire logic sig_ready, // consumer takes signature byte
  output logic [7:0] sig_data, // signature byte
  output logic sig_last, // last signature byte
  output logic link_sck, // serial clock to target
  output logic link_mosi, // serial data to target
  input wire logic link_miso, // serial data from target
  input wire logic handshake_busy_line // high while target busy
);

  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

  generate
    if (SCK_HALF < 3 || SCK_HALF > 255 || BUF_DEPTH < 2 ||
        (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_bad
      $error("unsupported parameter values");
    end
  endgenerate

  typedef enum logic [2:0] {
    S_IDLE,
    S_WAIT_CMD,
    S_SEND_CMD,
    S_WAIT_STATUS,
    S_RECV_STATUS,
    S_WAIT_DATA,
    S_RECV_DATA
  } state_t;

  state_t state_r;
  logic busy_m_r, busy_r, miso_m_r, miso_r;
  logic [8:0] idx_r;
  logic [7:0] len_r, sum_r;
  logic ok_r, sig_sel_r;
  logic [31:0] cyc_r, limit_r;
  logic [47:0] addr_r;
  logic xfer_r, sck_r, mosi_r;
  logic [7:0] sh_r, ph_r;
  logic [2:0] bit_r;
  logic done_r;
  blank_sig_pkg::result_t result_r;
  logic [7:0] status_r;
  logic [8:0] push_cnt_r;
  logic [8:0] buf_mem_r [BUF_DEPTH];
  logic [PW-1:0] wr_ptr_r, rd_ptr_r;
  logic [PW:0] cnt_r;

  logic [7:0] tx_byte, rx_byte;
  logic [8:0] last_idx, last_pay;
  logic byte_done, start_byte, in_payload, push, pop, rx_good;
  logic [31:0] nblk, blank_limit;

  // two-flop synchronisers on pins
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      busy_m_r <= 1'b1;
      busy_r <= 1'b1;
      miso_m_r <= 1'b0;
      miso_r <= 1'b0;
    end else begin
      busy_m_r <= handshake_busy_line;
      busy_r <= busy_m_r;
      miso_m_r <= link_miso;
      miso_r <= miso_m_r;
    end
  end

  assign last_idx = {1'b0, len_r} + 9'(blank_sig_pkg::IDX_TRAILER);
  assign last_pay = {1'b0, len_r} + 9'd1;
  assign rx_byte = {sh_r[6:0], miso_r};
  assign byte_done = xfer_r && (ph_r == 8'h00) && sck_r && (bit_r == 3'h7);
  assign in_payload = (idx_r >= 9'd2) && (idx_r <= last_pay);
  assign push = byte_done && (state_r == S_RECV_DATA) && in_payload;
  assign pop = sig_valid && sig_ready;
  assign rx_good = ok_r && (rx_byte == blank_sig_pkg::FRAME_ETX) &&
                   (sum_r == 8'h00);
  // frames start only in a transfer state, entered once busy released
  assign start_byte = !xfer_r && ((state_r == S_SEND_CMD) ||
                      (state_r == S_RECV_STATUS) ||
                      ((state_r == S_RECV_DATA) &&
                       (cnt_r < (PW+1)'(BUF_DEPTH))));

  // block count from the address range sets the blank check wait
  assign nblk = 32'((end_addr >> blank_sig_pkg::BLOCK_SHIFT) -
                    (start_addr >> blank_sig_pkg::BLOCK_SHIFT)) + 32'd1;
  assign blank_limit = 32'(BLANK_BASE) +
                       32'(BLANK_PER_BLOCK) * nblk;

  // command frame bytes
  always_comb begin
    tx_byte = blank_sig_pkg::DUMMY_BYTE;
    if (state_r == S_SEND_CMD) begin
      if (idx_r == 9'd0) begin
        tx_byte = blank_sig_pkg::FRAME_SOH;
      end else if (idx_r == 9'(blank_sig_pkg::IDX_LEN)) begin
        tx_byte = len_r;
      end else if (idx_r == 9'(blank_sig_pkg::IDX_CMD)) begin
        tx_byte = sig_sel_r ? blank_sig_pkg::SIGNATURE_CMD
                            : blank_sig_pkg::BLANK_CHECK_CMD;
      end else if (idx_r <= last_pay) begin
        case (idx_r - 9'(blank_sig_pkg::IDX_FIRST_PRM))
          9'd0: tx_byte = addr_r[47:40];
          9'd1: tx_byte = addr_r[39:32];
          9'd2: tx_byte = addr_r[31:24];
          9'd3: tx_byte = addr_r[23:16];
          9'd4: tx_byte = addr_r[15:8];
          default: tx_byte = addr_r[7:0];
        endcase
      end else if (idx_r == last_pay + 9'd1) begin
        tx_byte = 8'h00 - sum_r;
      end else begin
        tx_byte = blank_sig_pkg::FRAME_ETX;
      end
    end
  end

  // byte engine: data set with sck low, target samples on rise
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      xfer_r <= 1'b0;
      sck_r <= 1'b1;
      mosi_r <= 1'b1;
      sh_r <= 8'h00;
      bit_r <= 3'h0;
      ph_r <= 8'h00;
    end else if (start_byte) begin
      xfer_r <= 1'b1;
      sck_r <= 1'b0;
      mosi_r <= tx_byte[7];
      sh_r <= tx_byte;
      bit_r <= 3'h0;
      ph_r <= 8'(SCK_HALF - 1);
    end else if (xfer_r) begin
      if (ph_r != 8'h00) begin
        ph_r <= ph_r - 8'h01;
      end else if (!sck_r) begin
        sck_r <= 1'b1;
        ph_r <= 8'(SCK_HALF - 1);
      end else begin
        sh_r <= rx_byte;
        if (bit_r == 3'h7) begin
          xfer_r <= 1'b0;
        end else begin
          sck_r <= 1'b0;
          mosi_r <= sh_r[6];
          bit_r <= bit_r + 3'h1;
          ph_r <= 8'(SCK_HALF - 1);
        end
      end
    end
  end

  // command sequencer
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r <= S_IDLE;
      idx_r <= 9'h000;
      len_r <= 8'h00;
      sum_r <= 8'h00;
      ok_r <= 1'b0;
      sig_sel_r <= 1'b0;
      cyc_r <= 32'h0;
      limit_r <= 32'h0;
      addr_r <= 48'h0;
      done_r <= 1'b0;
      result_r <= blank_sig_pkg::RES_OK;
      status_r <= 8'h00;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (cmd_valid) begin
            sig_sel_r <= cmd_signature;
            addr_r <= {start_addr, end_addr};
            len_r <= cmd_signature ? blank_sig_pkg::SIG_CMD_LEN
                                   : blank_sig_pkg::BLANK_CMD_LEN;
            limit_r <= cmd_signature ? 32'(SIG_STATUS_TIMEOUT)
                                     : blank_limit;
            cyc_r <= 32'h0;
            state_r <= S_WAIT_CMD;
          end
        end
        S_WAIT_CMD, S_WAIT_STATUS, S_WAIT_DATA: begin
          idx_r <= 9'h000;
          sum_r <= 8'h00;
          if (!busy_r) begin
            cyc_r <= 32'h0;
            case (state_r)
              S_WAIT_CMD: state_r <= S_SEND_CMD;
              S_WAIT_STATUS: state_r <= S_RECV_STATUS;
              default: state_r <= S_RECV_DATA;
            endcase
          end else if (state_r == S_WAIT_CMD && cyc_r >= 32'(CMD_TIMEOUT)
                       || state_r != S_WAIT_CMD && cyc_r >= limit_r) begin
            done_r <= 1'b1;
            result_r <= blank_sig_pkg::RES_TIMEOUT;
            state_r <= S_IDLE;
          end else begin
            cyc_r <= cyc_r + 32'h1;
          end
        end
        S_SEND_CMD: begin
          if (byte_done) begin
            if (idx_r >= 9'd1 && idx_r <= last_pay) begin
              sum_r <= sum_r + tx_byte;
            end
            if (idx_r == last_idx) begin
              state_r <= S_WAIT_STATUS;
              status_r <= 8'h00;
            end else begin
              idx_r <= idx_r + 9'd1;
            end
          end
        end
        S_RECV_STATUS, S_RECV_DATA: begin
          if (byte_done) begin
            idx_r <= idx_r + 9'd1;
            if (idx_r == 9'd0) begin
              ok_r <= (rx_byte == blank_sig_pkg::FRAME_STX);
            end else if (idx_r == 9'd1) begin
              len_r <= rx_byte;
              sum_r <= rx_byte;
            end else if (idx_r != last_idx) begin
              sum_r <= sum_r + rx_byte;
              if (idx_r == 9'd2 && state_r == S_RECV_STATUS) begin
                status_r <= rx_byte;
              end
            end else if (state_r == S_RECV_DATA) begin
              done_r <= 1'b1;
              result_r <= rx_good ? blank_sig_pkg::RES_OK
                                  : blank_sig_pkg::RES_DATA_ERR;
              state_r <= S_IDLE;
            end else if (rx_good && status_r == blank_sig_pkg::ST_ACK &&
                         sig_sel_r) begin
              limit_r <= 32'(SIG_DATA_TIMEOUT);
              cyc_r <= 32'h0;
              state_r <= S_WAIT_DATA;
            end else begin
              done_r <= 1'b1;
              result_r <= (rx_good && status_r == blank_sig_pkg::ST_ACK) ?
                          blank_sig_pkg::RES_OK :
                          blank_sig_pkg::RES_ABNORMAL;
              state_r <= S_IDLE;
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // signature byte buffer
  generate
    for (genvar i = 0; i < BUF_DEPTH; i++) begin : g_buf
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          buf_mem_r[i] <= 9'h000;
        end else if (push && wr_ptr_r == PW'(i)) begin
          buf_mem_r[i] <= {idx_r == last_pay, rx_byte};
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      push_cnt_r <= 9'h000;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + PW'(1);
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + PW'(1);
      end
      cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
      if (state_r == S_WAIT_DATA) begin
        push_cnt_r <= 9'h000;
      end else if (push) begin
        push_cnt_r <= push_cnt_r + 9'd1;
      end
    end
  end

  assign cmd_ready = (state_r == S_IDLE);
  assign done = done_r;
  assign result = result_r;
  assign status_code = status_r;
  assign sig_valid = (cnt_r != '0);
  assign sig_data = buf_mem_r[rd_ptr_r][7:0];
  assign sig_last = buf_mem_r[rd_ptr_r][8];
  assign link_sck = sck_r;
  assign link_mosi = mosi_r;

  AST_FRAME_NOT_WHILE_BUSY: assert property (
    @(posedge clock) disable iff (reset)
    $rose(state_r == S_SEND_CMD) || $rose(state_r == S_RECV_STATUS) ||
    $rose(state_r == S_RECV_DATA) |-> !$past(busy_r))
    else $error("frame started while target busy");

  AST_CMD_TIMEOUT: assert property (
    @(posedge clock) disable iff (reset)
    state_r == S_WAIT_CMD && busy_r && cyc_r >= 32'(CMD_TIMEOUT) |=>
    done_r && result_r == blank_sig_pkg::RES_TIMEOUT && state_r == S_IDLE)
    else $error("command busy time-out not reported");

  AST_BLANK_LIMIT: assert property (
    @(posedge clock) disable iff (reset)
    state_r == S_IDLE && cmd_valid && !cmd_signature |=>
    limit_r == $past(blank_limit))
    else $error("blank check limit not taken from block range");

  AST_BLANK_LEN: assert property (
    @(posedge clock) disable iff (reset)
    start_byte && state_r == S_SEND_CMD && idx_r == 9'd1 && !sig_sel_r |->
    tx_byte == 8'h07)
    else $error("blank check length field wrong");

  AST_SIG_LEN: assert property (
    @(posedge clock) disable iff (reset)
    start_byte && state_r == S_SEND_CMD && idx_r == 9'd1 && sig_sel_r |->
    tx_byte == 8'h01)
    else $error("signature length field wrong");

  AST_BLANK_ENDS_ON_STATUS: assert property (
    @(posedge clock) disable iff (reset)
    state_r == S_RECV_STATUS && byte_done && idx_r == last_idx &&
    !sig_sel_r |=> done_r && state_r == S_IDLE)
    else $error("blank check did not end on status frame");

  AST_SIG_ACK_TO_DATA: assert property (
    @(posedge clock) disable iff (reset)
    state_r == S_RECV_STATUS && byte_done && idx_r == last_idx &&
    sig_sel_r && rx_good && status_r == 8'h06 |=>
    state_r == S_WAIT_DATA && !done_r)
    else $error("signature ack did not lead to data frame");

  AST_DATA_BAD_SUM: assert property (
    @(posedge clock) disable iff (reset)
    state_r == S_RECV_DATA && byte_done && idx_r == last_idx &&
    sum_r != 8'h00 |=> done_r && result_r == blank_sig_pkg::RES_DATA_ERR)
    else $error("data frame checksum error missed");

  AST_PAYLOAD_COUNT: assert property (
    @(posedge clock) disable iff (reset)
    $rose(done_r) && sig_sel_r && result_r == blank_sig_pkg::RES_OK |->
    push_cnt_r == {1'b0, len_r})
    else $error("signature byte count differs from length field");

  AST_TIMEOUT_CAUSE: assert property (
    @(posedge clock) disable iff (reset)
    done_r && result_r == blank_sig_pkg::RES_TIMEOUT |->
    $past(busy_r) && ($past(state_r) == S_WAIT_CMD ||
    $past(cyc_r) >= $past(limit_r)))
    else $error("time-out reported without busy overrun");

  COV_BLANK_OK: cover property (@(posedge clock) disable iff (reset)
    done_r && !sig_sel_r && result_r == blank_sig_pkg::RES_OK);
  COV_SIG_OK: cover property (@(posedge clock) disable iff (reset)
    done_r && sig_sel_r && result_r == blank_sig_pkg::RES_OK);
  COV_TIMEOUT: cover property (@(posedge clock) disable iff (reset)
    done_r && result_r == blank_sig_pkg::RES_TIMEOUT);
  COV_BUF_FULL: cover property (@(posedge clock) disable iff (reset)
    cnt_r == (PW+1)'(BUF_DEPTH) && !sig_ready);

endmodule : blank_sig_host

// [verification/flash_target_model.sv]
`timescale 1ns/10ps
module flash_target_model #(
  parameter logic [23:0] FLASH_END = 24'h03FFFF
) (
  input wire logic clock, // target clock
  input wire logic link_sck, // host serial clock
  input wire logic link_mosi, // host data
  output logic link_miso, // target data
  output logic handshake_busy_line, // high while busy
  input wire logic hold_busy, // extra busy from bench
  input wire logic clear, // drop partial frames
  input wire logic [7:0] force_st, // nonzero replaces status
  input wire logic not_blank, // range holds data
  input wire logic bad_sum, // spoil data frame sum
  input wire logic bad_st, // spoil status frame sum
  input wire logic [31:0] busy_cmd, // busy after command
  input wire logic [31:0] busy_dat, // busy before data
  input wire logic [31:0] sig_len, // signature length
  input wire logic [7:0] sig_bytes [8], // signature
  output logic [7:0] last_len, // received length field
  output logic [7:0] last_cmd // received command
);
  typedef logic [7:0] bq_t[$];
  bq_t rx, tx, p;
  logic [7:0] sh, st, s;
  logic [23:0] sa, ea;
  logic busy_r = 1'b0;
  logic more = 1'b0;
  int nbit = 0;
  assign handshake_busy_line = busy_r | hold_busy;
  initial link_miso = 1'b1;
  always @(posedge clear) begin
    rx.delete();
    tx.delete();
    nbit = 0;
  end
  // released line toggles every bit
  always @(negedge link_sck) begin
    if (tx.size() != 0) link_miso = tx[0][7 - nbit];
    else link_miso = ~link_miso;
  end
  task automatic send(input bq_t f, input logic spoil, input int n);
    busy_r <= 1'b1;
    repeat (n) @(posedge clock);
    s = 8'(f.size());
    foreach (f[i]) s += f[i];
    tx = {8'h02, 8'(f.size()), f, 8'(8'h00 - s + spoil), 8'h03};
    busy_r <= 1'b0;
  endtask : send
  task automatic answer();
    int n;
    n = rx.size();
    s = 8'h00;
    for (int i = 1; i < n - 1; i++) s += rx[i];
    last_len = rx[1];
    last_cmd = rx[2];
    sa = {rx[3], rx[4], rx[5]};
    ea = {rx[6], rx[7], rx[8]};
    if (n != rx[1] + 4 || rx[n - 1] !== 8'h03) st = 8'h15;
    else if (s !== 8'h00) st = 8'h07;
    else if (rx[2] == blank_sig_pkg::BLANK_CHECK_CMD &&
             (sa[10:0] != 0 || ea[10:0] != 11'h7FF ||
              ea > FLASH_END || sa > ea)) st = 8'h05;
    else if (rx[2] == blank_sig_pkg::BLANK_CHECK_CMD && not_blank)
      st = 8'h18;
    else st = 8'h06;
    if (force_st != 8'h00) st = force_st;
    more = rx[2] == blank_sig_pkg::SIGNATURE_CMD && st == 8'h06;
    rx.delete();
    send({st}, bad_st, busy_cmd);
  endtask : answer
  always @(posedge link_sck) begin
    sh = {sh[6:0], link_mosi};
    nbit++;
    if (nbit == 8) begin
      nbit = 0;
      if (tx.size() != 0) begin
        void'(tx.pop_front());
        if (tx.size() == 0 && more) begin
          more = 1'b0;
          p = {};
          for (int i = 0; i < sig_len; i++) p.push_back(sig_bytes[i]);
          send(p, bad_sum, busy_dat);
        end
      end else begin
        rx.push_back(sh);
        if (rx[0] !== 8'h01) rx.delete();
        else if (rx.size() > 1 && (rx.size() == rx[1] + 4 || rx.size() > 12))
          answer();
      end
    end
  end
endmodule : flash_target_model

// [verification/blank_sig_host_tb.sv]
`timescale 1ns/10ps
module blank_sig_host_tb;
  localparam int CTO = 100;
  localparam int BB = 100;
  localparam int BPB = 20;
  localparam int SST = 150;
  localparam int SDT = 120;
  localparam logic [23:0] FEND = 24'h03FFFF;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_signature = 1'b0;
  logic [23:0] start_addr = 24'h000000;
  logic [23:0] end_addr = 24'h000000;
  logic sig_ready = 1'b0;
  logic cmd_ready, done, sig_valid, sig_last, link_sck, link_mosi;
  logic link_miso, handshake_busy_line;
  logic [7:0] status_code, sig_data, last_len, last_cmd;
  blank_sig_pkg::result_t result;
  logic hold_busy = 1'b0;
  logic clear = 1'b0;
  logic [7:0] force_st = 8'h00;
  logic not_blank = 1'b0;
  logic bad_sum = 1'b0;
  logic bad_st = 1'b0;
  logic stall = 1'b0;
  logic pre_to = 1'b0;
  int busy_cmd = 5;
  int busy_dat = 5;
  int sig_len = 4;
  int errors = 0;
  int samples_checked = 0;
  int took, sb, nb;
  logic [7:0] sig_bytes [8];
  logic [7:0] codes [4] = '{8'h05, 8'h07, 8'h15, 8'h18};
  logic [8:0] got[$];
  blank_sig_host #(.CMD_TIMEOUT(CTO), .BLANK_BASE(BB), .BLANK_PER_BLOCK(BPB),
    .SIG_STATUS_TIMEOUT(SST), .SIG_DATA_TIMEOUT(SDT), .SCK_HALF(4),
    .BUF_DEPTH(2)) blank_sig_host_inst (.clock(clock), .reset(reset),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_signature(cmd_signature), .start_addr(start_addr),
    .end_addr(end_addr), .done(done), .result(result),
    .status_code(status_code), .sig_valid(sig_valid),
    .sig_ready(sig_ready), .sig_data(sig_data), .sig_last(sig_last),
    .link_sck(link_sck), .link_mosi(link_mosi), .link_miso(link_miso),
    .handshake_busy_line(handshake_busy_line));
  flash_target_model #(.FLASH_END(FEND)) flash_target_model_inst (
    .clock(clock), .link_sck(link_sck), .link_mosi(link_mosi),
    .link_miso(link_miso), .handshake_busy_line(handshake_busy_line),
    .hold_busy(hold_busy), .clear(clear), .force_st(force_st),
    .not_blank(not_blank), .bad_sum(bad_sum), .bad_st(bad_st),
    .busy_cmd(busy_cmd),
    .busy_dat(busy_dat), .sig_len(sig_len), .sig_bytes(sig_bytes),
    .last_len(last_len), .last_cmd(last_cmd));
  initial forever #50 clock = ~clock;
  always @(posedge clock) begin
    if (sig_valid === 1'b1 && sig_ready === 1'b1)
      got.push_back({sig_last, sig_data});
    sig_ready <= !stall && ($urandom % 4 != 0);
  end
  task automatic chk(input string what, input logic [31:0] exp, seen);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  // no falling link clock edge while the target is busy
  always @(negedge link_sck)
    if (!reset) chk("busy at bit", 0, handshake_busy_line);
  task automatic end_sim();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic run(input logic sig, input logic [23:0] sa, ea);
    int st, lim, er;
    logic [8:0] q[$];
    logic [7:0] cmd;
    cmd = sig ? blank_sig_pkg::SIGNATURE_CMD : blank_sig_pkg::BLANK_CHECK_CMD;
    st = 8'h06;
    if (force_st != 0) st = force_st;
    else if (!sig && (sa[10:0] != 0 || ea[10:0] != 11'h7FF || ea > FEND ||
             sa > ea)) st = 8'h05;
    else if (!sig && not_blank) st = 8'h18;
    lim = sig ? SST : BB + BPB * (int'(ea >> 11) - int'(sa >> 11) + 1);
    if (pre_to || busy_cmd > lim) er = 2;
    else if (st != 8'h06 || bad_st) er = 1;
    else if (sig && busy_dat > SDT) er = 2;
    else er = (sig && bad_sum) ? 3 : 0;
    if (er != 2 && sig && st == 8'h06)
      for (int i = 0; i < sig_len; i++)
        q.push_back({i == sig_len - 1, sig_bytes[i]});
    got.delete();
    took = 0;
    cmd_valid <= 1'b1;
    cmd_signature <= sig;
    start_addr <= sa;
    end_addr <= ea;
    @(posedge clock);
    cmd_valid <= 1'b0;
    while (done !== 1'b1) begin
      @(posedge clock);
      took++;
      if (took == 1) chk("ready low", 0, cmd_ready);
      if (took > 30000) begin
        chk("done", 1, 0);
        end_sim();
      end
    end
    chk("result", er, result);
    chk("ready", 1, cmd_ready);
    if (!pre_to) chk("cmd", cmd, last_cmd);
    if (er != 2) chk("status", st, status_code);
    if (!pre_to) chk("len", sig ? 8'h01 : 8'h07, last_len);
    for (int i = 0; i < 300 && got.size() < q.size(); i++) @(posedge clock);
    chk("sig count", q.size(), got.size());
    foreach (q[i]) chk("sig byte", q[i], got[i]);
    if (er == 2) begin
      repeat (busy_cmd + busy_dat + 50) @(posedge clock);
      clear <= 1'b1;
      @(posedge clock);
      clear <= 1'b0;
    end
  endtask : run
  initial begin
    void'($urandom(32'h304F));
    for (int i = 0; i < 8; i++) sig_bytes[i] = 8'($urandom);
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    clear <= 1'b1;
    @(posedge clock);
    clear <= 1'b0;
    repeat (3) begin
      sb = $urandom % 8;
      nb = 1 + $urandom % 4;
      run(0, 24'(sb << 11), 24'(((sb + nb) << 11) - 1));
    end
    run(0, 24'h000800, 24'h000FFE);
    run(0, 24'h03F800, 24'h040FFF);
    run(0, 24'h000010, 24'h0007FF);
    not_blank = 1'b1;
    run(0, 24'h000000, 24'h0007FF);
    not_blank = 1'b0;
    bad_st = 1'b1;
    run(0, 24'h000000, 24'h0007FF);
    bad_st = 1'b0;
    foreach (codes[i]) begin
      force_st = codes[i];
      run(0, 24'h000000, 24'h0007FF);
      run(1, 24'h000000, 24'h000000);
    end
    force_st = 8'h00;
    repeat (3) begin
      sig_len = 1 + $urandom % 8;
      run(1, 24'h000000, 24'h000000);
    end
    bad_sum = 1'b1;
    run(1, 24'h000000, 24'h000000);
    bad_sum = 1'b0;
    sig_len = 8;
    stall <= 1'b1;
    fork
      run(1, 24'h000000, 24'h000000);
      begin
        repeat (1500) @(posedge clock);
        chk("held bytes", 0, got.size());
        stall <= 1'b0;
      end
    join
    pre_to = 1'b1;
    hold_busy <= 1'b1;
    repeat (4) @(posedge clock);
    run(0, 24'h000000, 24'h0007FF);
    chk("wait", 1, took >= CTO && took <= CTO + 10);
    pre_to = 1'b0;
    fork
      begin
        repeat (40) @(posedge clock);
        hold_busy <= 1'b0;
      end
    join_none
    run(0, 24'h000000, 24'h0007FF);
    chk("late start", 1, took > 40);
    busy_cmd = BB + BPB * 2 - 10;
    run(0, 24'h001000, 24'h001FFF);
    busy_cmd = BB + BPB * 2 + 10;
    run(0, 24'h001000, 24'h001FFF);
    busy_cmd = SST + 10;
    run(1, 24'h000000, 24'h000000);
    busy_cmd = 5;
    busy_dat = SDT - 10;
    run(1, 24'h000000, 24'h000000);
    busy_dat = SDT + 10;
    run(1, 24'h000000, 24'h000000);
    end_sim();
  end
endmodule : blank_sig_host_tb
